// file: src/shb_regs.svh
/*
  Register offsets, reset values, address-map nibbles and access sizes
  of the shared bus arbiter. Included by the arbiter module only.
*/
`ifndef SHB_REGS_SVH
`define SHB_REGS_SVH
`define SHB_CPU_PRIO_OFS    12'h000
`define SHB_PCIE_PRIO_OFS   12'h004
`define SHB_ACC_PRIO_OFS    12'h008
`define SHB_TOKEN_EN_OFS    12'h00c
`define SHB_PERIOD_OFS      12'h010
`define SHB_CPU_WEIGHT_OFS  12'h014
`define SHB_PCIE_WEIGHT_OFS 12'h018
`define SHB_ACC_WEIGHT_OFS  12'h01c
`define SHB_STATUS_OFS      12'h020
`define SHB_TOKEN_OFS       12'h024
`define SHB_PRIO_RST        4'h0
`define SHB_PRIO_TOP        4'hf
`define SHB_PERIOD_RST      16'h0800
`define SHB_WEIGHT_RST      16'h0000
`define SHB_MIRROR_NIB      4'h0
`define SHB_MIRROR2_NIB     4'h1
`define SHB_FLASH_NIB       4'h4
`define SHB_CHIP_NIB        4'h7
`define SHB_DRAM_LO_NIB     4'h8
`define SHB_DRAM_HI_NIB     4'hb
`define SHB_PCIE_LO_NIB     4'hc
`define SHB_CHIP_LOCAL_BLK  4'h0
`define SHB_FAST_ONE_TOP    16'h7101
`define SHB_FAST_TWO_TOP    16'h7102
`define SHB_SIZE_WORD       2'h2
`endif

// file: src/shb_pkg.sv
/*
  Types of the shared bus arbiter: beat state machine and target regions.
  Assumes nothing of its surroundings.
*/
package shb_pkg;
  typedef enum {ST_ARB, ST_BEAT, ST_MEM, ST_RREG, ST_DONE} shb_state_t;
  typedef enum {RG_NONE, RG_FLASH, RG_DRAM, RG_PCIE, RG_CHIP} shb_region_t;
endpackage

// file: src/shb_arbiter.sv
/*
  Shared bus arbiter with strict and weighted-token arbitration, region
  decode, chip-register write buffer and APB configuration slave.
  Assumes masters hold a beat until their ready pulse, downstream ports
  answer with a one-cycle ack, and all inputs are on clock_i.
*/
// How it works
// R1: reset priorities tie, so index order makes the cpu master win.
// R2: each master has its own programmable four-bit priority level.
// R3: level 15 is the highest level in the strict ordering.
// R4: in token mode, masters without tokens still get an idle bus.
// R5: token counters reload from their weights when a refresh period begins.
// R6: refresh period length is programmable; a new period starts on expiry.
// R7: each cycle a master owns the bus its token counter drops by one.
// R8: a master with zero tokens is low priority until the next refresh.
// R9: a requester holding tokens beats every requester holding none.
// R10: ties inside each token group are settled by the priority levels.
// R11: weight 0 means unlimited tokens, never demoted.
// R12: masters use only 32-bit accesses to chip registers; others get an error.
// R13: one-word write buffer; a second write stalls until it drains.
// R14: a chip-register read stalls the bus until data returns.
// R15: a register read waits for the buffered write to finish.
// R16: local register block is flagged fast toward the register port.
// R17: switch-core block is flagged slow, its two fast targets fast.
// R18: flash-region reads go to the flash boot controller port.
// R19: masters never write the flash region; such writes get an error.
// R20: dram-region accesses are forwarded on the dram controller port.
// R21: pcie-region accesses are forwarded on the pcie endpoint port.
// R22: byte addresses, 8/16/32-bit sizes and 32-bit word bursts pass through.
// R23: tokens saturate at zero; owner keeps the bus to the last beat.
`timescale 1ns/10ps
`include "shb_regs.svh"
module shb_arbiter import shb_pkg::*; #(
  parameter int          NM           = 3,
  parameter int          TW           = 16,
  parameter logic [15:0] FAST_ONE_TOP = `SHB_FAST_ONE_TOP, // arbitrary value
  parameter logic [15:0] FAST_TWO_TOP = `SHB_FAST_TWO_TOP  // arbitrary value
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        boot_mode_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        mst_req_i   [NM],
  input  wire logic [31:0] mst_addr_i  [NM],
  input  wire logic        mst_write_i [NM],
  input  wire logic [1:0]  mst_size_i  [NM],
  input  wire logic [31:0] mst_wdata_i [NM],
  input  wire logic        mst_last_i  [NM],
  output logic      [NM-1:0] mst_ready_o,
  output logic      [31:0] mst_rdata_o,
  output logic             mst_err_o,
  output logic      [2:0]  mem_sel_o,
  output logic      [31:0] mem_addr_o,
  output logic             mem_write_o,
  output logic      [1:0]  mem_size_o,
  output logic      [31:0] mem_wdata_o,
  output logic             mem_last_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  output logic             reg_req_o,
  output logic      [31:0] reg_addr_o,
  output logic             reg_write_o,
  output logic      [31:0] reg_wdata_o,
  output logic             reg_fast_o,
  input  wire logic        reg_ack_i,
  input  wire logic [31:0] reg_rdata_i
);
  shb_state_t  state_ff;
  shb_region_t region;
  logic [1:0]    gnt_ff;
  logic [1:0]    winner;
  logic [3:0]    prio_ff   [NM];
  logic [TW-1:0] weight_ff [NM];
  logic [TW-1:0] tok_ff    [NM];
  logic [NM-1:0] has_tok;
  logic [TW-1:0] period_ff;
  logic [TW-1:0] ref_ff;
  logic          en_ff;
  logic          reload;
  logic          wbuf_full_ff;
  logic [31:0]   wbuf_addr_ff;
  logic [31:0]   wbuf_data_ff;
  logic          wbuf_fast_ff;
  logic          reg_req_ff;
  logic          reg_write_ff;
  logic          bad;
  logic          fast;
  logic          fill_wb;
  logic          issue_rd;
  logic [31:0]   cur_addr;
  logic          cur_write;
  logic          cur_last;

  assign cur_addr  = mst_addr_i[gnt_ff];
  assign cur_write = mst_write_i[gnt_ff];
  assign cur_last  = mst_last_i[gnt_ff];

  // region decode of the owner's current beat
  always_comb begin
    region = RG_NONE;
    if (cur_addr[31:28] == `SHB_MIRROR_NIB) begin
      region = boot_mode_i ? RG_FLASH : RG_DRAM;
    end else if (cur_addr[31:28] == `SHB_MIRROR2_NIB) begin
      region = boot_mode_i ? RG_NONE : RG_DRAM;
    end else if (cur_addr[31:28] == `SHB_FLASH_NIB) begin
      region = RG_FLASH; // R18
    end else if (cur_addr[31:28] == `SHB_CHIP_NIB) begin
      region = RG_CHIP;
    end else if (cur_addr[31:28] >= `SHB_DRAM_LO_NIB && cur_addr[31:28] <= `SHB_DRAM_HI_NIB) begin
      region = RG_DRAM; // R20
    end else if (cur_addr[31:28] >= `SHB_PCIE_LO_NIB) begin
      region = RG_PCIE; // R21
    end
  end

  assign bad = (region == RG_NONE) || (region == RG_FLASH && cur_write) || // R19
               (region == RG_CHIP && mst_size_i[gnt_ff] != `SHB_SIZE_WORD); // R12
  assign fast = (cur_addr[27:24] == `SHB_CHIP_LOCAL_BLK) || // R16
                (cur_addr[31:16] == FAST_ONE_TOP) || (cur_addr[31:16] == FAST_TWO_TOP); // R17
  assign fill_wb  = state_ff == ST_BEAT && mst_req_i[gnt_ff] && !bad && region == RG_CHIP &&
                    cur_write && !wbuf_full_ff; // R13
  assign issue_rd = state_ff == ST_BEAT && mst_req_i[gnt_ff] && !bad && region == RG_CHIP &&
                    !cur_write && !wbuf_full_ff && !reg_req_ff; // R15

  // token counters, one per master
  assign reload = en_ff && ref_ff == '0;
  for (genvar m = 0; m < NM; m++) begin : g_tok
    assign has_tok[m] = !en_ff || weight_ff[m] == '0 || tok_ff[m] != '0; // R8 R11
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        tok_ff[m] <= TW'(`SHB_WEIGHT_RST);
      end else if (ce_i) begin
        if (!en_ff || reload) begin
          tok_ff[m] <= weight_ff[m]; // R5
        end else if (state_ff != ST_ARB && gnt_ff == 2'(m) && tok_ff[m] != '0) begin
          tok_ff[m] <= tok_ff[m] - 1'b1; // R7 R23
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ref_ff <= TW'(`SHB_PERIOD_RST);
    end else if (ce_i) begin
      if (!en_ff || reload) begin
        ref_ff <= period_ff - 1'b1; // R6
      end else begin
        ref_ff <= ref_ff - 1'b1;
      end
    end
  end

  // key = {holds tokens, level}; strict greater keeps lower index on ties
  always_comb begin
    logic [4:0] best;
    best   = 5'h00;
    winner = 2'h0;
    for (int m = 0; m < NM; m++) begin
      if (mst_req_i[m] && ({has_tok[m], prio_ff[m]} > best || winner == 2'h0 && !mst_req_i[0])) begin
        if (!(m > 0 && mst_req_i[winner] && {has_tok[m], prio_ff[m]} <= best)) begin
          best   = {has_tok[m], prio_ff[m]}; // R9 R10 R3 R4
          winner = 2'(m); // R1
        end
      end
    end
  end

  // beat state machine of the bus owner
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff    <= ST_ARB;
      gnt_ff      <= 2'h0;
      mst_rdata_o <= 32'h0;
      mst_err_o   <= 1'b0;
    end else if (ce_i) begin
      case (state_ff)
        ST_ARB: begin
          if (mst_req_i[0] || mst_req_i[1] || mst_req_i[2]) begin
            gnt_ff   <= winner;
            state_ff <= ST_BEAT;
          end
        end
        ST_BEAT: begin
          mst_err_o <= 1'b0;
          if (!mst_req_i[gnt_ff]) begin
            state_ff <= ST_ARB;
          end else if (bad) begin
            mst_err_o   <= 1'b1;
            mst_rdata_o <= 32'h0;
            state_ff    <= ST_DONE;
          end else if (region != RG_CHIP) begin
            state_ff <= ST_MEM;
          end else if (fill_wb) begin
            state_ff <= ST_DONE;
          end else if (issue_rd) begin
            state_ff <= ST_RREG; // R14
          end
        end
        ST_MEM: begin
          if (mem_ack_i) begin
            mst_rdata_o <= mem_rdata_i;
            state_ff    <= ST_DONE;
          end
        end
        ST_RREG: begin
          if (reg_ack_i) begin
            mst_rdata_o <= reg_rdata_i; // R14
            state_ff    <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_ff <= cur_last ? ST_ARB : ST_BEAT; // R23
        end
        default: state_ff <= ST_ARB;
      endcase
    end
  end

  for (genvar m = 0; m < NM; m++) begin : g_rdy
    assign mst_ready_o[m] = state_ff == ST_DONE && gnt_ff == 2'(m);
  end

  // forwarding port toward flash, dram and pcie controllers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mem_sel_o   <= 3'h0;
      mem_addr_o  <= 32'h0;
      mem_write_o <= 1'b0;
      mem_size_o  <= 2'h0;
      mem_wdata_o <= 32'h0;
      mem_last_o  <= 1'b0;
    end else if (ce_i) begin
      if (mem_ack_i) begin
        mem_sel_o <= 3'h0;
      end else if (state_ff == ST_BEAT && mst_req_i[gnt_ff] && !bad && region != RG_CHIP) begin
        mem_sel_o   <= {region == RG_PCIE, region == RG_DRAM, region == RG_FLASH}; // R18 R20 R21
        mem_addr_o  <= cur_addr; // R22
        mem_write_o <= cur_write;
        mem_size_o  <= mst_size_i[gnt_ff];
        mem_wdata_o <= mst_wdata_i[gnt_ff];
        mem_last_o  <= cur_last;
      end
    end
  end

  // chip-register write buffer and register port
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wbuf_full_ff <= 1'b0;
      wbuf_addr_ff <= 32'h0;
      wbuf_data_ff <= 32'h0;
      wbuf_fast_ff <= 1'b0;
    end else if (ce_i) begin
      if (fill_wb) begin
        wbuf_full_ff <= 1'b1; // R13
        wbuf_addr_ff <= cur_addr;
        wbuf_data_ff <= mst_wdata_i[gnt_ff];
        wbuf_fast_ff <= fast;
      end else if (reg_req_ff && reg_write_ff && reg_ack_i) begin
        wbuf_full_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_req_ff   <= 1'b0;
      reg_write_ff <= 1'b0;
      reg_addr_o   <= 32'h0;
      reg_wdata_o  <= 32'h0;
      reg_fast_o   <= 1'b0;
    end else if (ce_i) begin
      if (reg_req_ff && reg_ack_i) begin
        reg_req_ff <= 1'b0;
      end else if (!reg_req_ff && wbuf_full_ff) begin
        reg_req_ff   <= 1'b1;
        reg_write_ff <= 1'b1;
        reg_addr_o   <= wbuf_addr_ff;
        reg_wdata_o  <= wbuf_data_ff;
        reg_fast_o   <= wbuf_fast_ff;
      end else if (issue_rd) begin
        reg_req_ff   <= 1'b1; // R15
        reg_write_ff <= 1'b0;
        reg_addr_o   <= cur_addr;
        reg_fast_o   <= fast; // R16 R17
      end
    end
  end
  assign reg_req_o   = reg_req_ff;
  assign reg_write_o = reg_write_ff;

  // apb configuration slave, zero wait states
  logic [11:0] ofs;
  logic        hit;
  logic [31:0] rd;
  assign ofs      = {paddr_i[11:2], 2'b00};
  assign pready_o = 1'b1;
  always_comb begin
    hit = 1'b1;
    rd  = 32'h0;
    case (ofs)
      `SHB_CPU_PRIO_OFS:    rd = {28'h0, prio_ff[0]};
      `SHB_PCIE_PRIO_OFS:   rd = {28'h0, prio_ff[1]};
      `SHB_ACC_PRIO_OFS:    rd = {28'h0, prio_ff[2]};
      `SHB_TOKEN_EN_OFS:    rd = {31'h0, en_ff};
      `SHB_PERIOD_OFS:      rd = 32'(period_ff);
      `SHB_CPU_WEIGHT_OFS:  rd = 32'(weight_ff[0]);
      `SHB_PCIE_WEIGHT_OFS: rd = 32'(weight_ff[1]);
      `SHB_ACC_WEIGHT_OFS:  rd = 32'(weight_ff[2]);
      `SHB_STATUS_OFS:      rd = {27'h0, reg_req_ff, wbuf_full_ff, state_ff != ST_ARB, gnt_ff};
      `SHB_TOKEN_OFS:       rd = {29'h0, has_tok};
      default:              hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (ce_i && psel_i && !penable_i) begin
      prdata_o  <= pwrite_i ? 32'h0 : rd;
      pslverr_o <= !hit;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prio_ff   <= '{default: `SHB_PRIO_RST}; // R1
      weight_ff <= '{default: TW'(`SHB_WEIGHT_RST)};
      period_ff <= TW'(`SHB_PERIOD_RST);
      en_ff     <= 1'b0;
    end else if (ce_i && psel_i && penable_i && pwrite_i) begin
      case (ofs)
        `SHB_CPU_PRIO_OFS:    prio_ff[0]   <= pwdata_i[3:0]; // R2
        `SHB_PCIE_PRIO_OFS:   prio_ff[1]   <= pwdata_i[3:0];
        `SHB_ACC_PRIO_OFS:    prio_ff[2]   <= pwdata_i[3:0];
        `SHB_TOKEN_EN_OFS:    en_ff        <= pwdata_i[0];
        `SHB_PERIOD_OFS:      period_ff    <= pwdata_i[TW-1:0]; // R6
        `SHB_CPU_WEIGHT_OFS:  weight_ff[0] <= pwdata_i[TW-1:0];
        `SHB_PCIE_WEIGHT_OFS: weight_ff[1] <= pwdata_i[TW-1:0];
        `SHB_ACC_WEIGHT_OFS:  weight_ff[2] <= pwdata_i[TW-1:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  chk_ready_onehot: assert property ($onehot0(mst_ready_o)) // R23
    else $error("more than one master ready");
  chk_default_cpu: assert property (ce_i && state_ff == ST_ARB && mst_req_i[0] && !en_ff &&
    prio_ff[0] == prio_ff[1] && prio_ff[0] == prio_ff[2] |=> gnt_ff == 2'h0) // R1
    else $error("cpu lost a tie");
  chk_top_level: assert property (ce_i && state_ff == ST_ARB && mst_req_i[1] && !en_ff &&
    prio_ff[1] == `SHB_PRIO_TOP && prio_ff[0] != `SHB_PRIO_TOP |=> gnt_ff != 2'h0) // R3
    else $error("level 15 did not outrank cpu");
  chk_token_first: assert property (ce_i && state_ff == ST_ARB && mst_req_i[0] && mst_req_i[1]
    && !has_tok[0] && has_tok[1] |=> gnt_ff != 2'h0) // R9
    else $error("master without tokens won");
  chk_token_dec: assert property (ce_i && en_ff && !reload && state_ff != ST_ARB &&
    gnt_ff == 2'h1 && tok_ff[1] != '0 |=> tok_ff[1] == $past(tok_ff[1]) - 1'b1) // R7
    else $error("token not spent");
  chk_token_reload: assert property (ce_i && reload |=> tok_ff[2] == $past(weight_ff[2]) &&
    ref_ff == $past(period_ff) - 1'b1) // R5
    else $error("refresh did not reload");
  chk_unlimited: assert property (weight_ff[0] == '0 |-> has_tok[0]) // R11
    else $error("unlimited master demoted");
  chk_wbuf_stall: assert property (ce_i && state_ff == ST_BEAT && mst_req_i[gnt_ff] && !bad &&
    region == RG_CHIP && cur_write && wbuf_full_ff |=> state_ff == ST_BEAT) // R13
    else $error("second write not stalled");
  chk_read_order: assert property (reg_req_ff && !reg_write_ff |-> !wbuf_full_ff ##0
    !$past(wbuf_full_ff) || $past(reg_req_ff)) // R15
    else $error("read overtook buffered write");
  chk_read_hold: assert property (state_ff == ST_RREG && !reg_ack_i |-> mst_ready_o == '0) // R14
    else $error("read released before data");
endmodule // shb_arbiter

// file: dv/shb_target_model.sv
/*
  Downstream responders of the shared bus arbiter: memory and register ports.
  Assumes sel and req stay up until their ack, all on clock_i.
*/
`timescale 1ns/10ps
module shb_target_model (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  delay_i,
  input  wire logic [2:0]  mem_sel_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic        reg_req_i,
  input  wire logic [31:0] reg_addr_i,
  output logic             mem_ack_o,
  output logic      [31:0] mem_rdata_o,
  output logic             reg_ack_o,
  output logic      [31:0] reg_rdata_o
);
  logic [3:0] mem_cnt_ff;
  logic [3:0] reg_cnt_ff;
  // data is valid only with ack; otherwise a value that never matches
  assign mem_rdata_o = mem_ack_o ? mem_addr_i ^ 32'h0000_a5a5 : ~mem_addr_i;
  assign reg_rdata_o = reg_ack_o ? reg_addr_i ^ 32'h0000_5a5a : ~reg_addr_i;
  always_ff @(posedge clock_i) begin
    if (rst_i || mem_sel_i == 3'h0 || mem_ack_o) begin
      mem_ack_o  <= 1'b0;
      mem_cnt_ff <= 4'h0;
    end else if (mem_cnt_ff == delay_i) begin
      mem_ack_o <= 1'b1;
    end else begin
      mem_cnt_ff <= mem_cnt_ff + 4'h1;
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i || !reg_req_i || reg_ack_o) begin
      reg_ack_o  <= 1'b0;
      reg_cnt_ff <= 4'h0;
    end else if (reg_cnt_ff == delay_i) begin
      reg_ack_o <= 1'b1;
    end else begin
      reg_cnt_ff <= reg_cnt_ff + 4'h1;
    end
  end
endmodule // shb_target_model

// file: dv/tb_top.sv
/*
  Self-checking bench of the shared bus arbiter.
  Assumes the arbiter and the downstream responder model are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        mst_req_i [3];
  logic [31:0] mst_addr_i [3];
  logic        mst_write_i [3];
  logic [1:0]  mst_size_i [3];
  logic [31:0] mst_wdata_i [3];
  logic        mst_last_i [3];
  logic [2:0]  mst_ready_o;
  logic [31:0] mst_rdata_o;
  logic        mst_err_o;
  logic [2:0]  mem_sel_o;
  logic [31:0] mem_addr_o;
  logic        mem_write_o;
  logic [1:0]  mem_size_o;
  logic [31:0] mem_wdata_o;
  logic        mem_last_o;
  logic        mem_ack_i;
  logic [31:0] mem_rdata_i;
  logic        reg_req_o;
  logic [31:0] reg_addr_o;
  logic        reg_write_o;
  logic [31:0] reg_wdata_o;
  logic        reg_fast_o;
  logic        reg_ack_i;
  logic [31:0] reg_rdata_i;
  logic [3:0]  delay_i = 4'h0;
  logic [2:0]  seen_sel;
  logic        seen_fast;
  logic [31:0] seen_maddr;
  logic [3:0]  seen_mctl;
  logic [31:0] seen_mwd;
  logic [31:0] seen_raddr;
  logic        seen_rw;
  logic [31:0] seen_rwd;
  logic        boot_mode = 1'b0;
  int          errors = 0;
  int          tests_run = 0;
  longint      cyc = 0;

  shb_arbiter shb_arbiter_inst (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
    .boot_mode_i(boot_mode), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .mst_req_i(mst_req_i), .mst_addr_i(mst_addr_i),
    .mst_write_i(mst_write_i), .mst_size_i(mst_size_i), .mst_wdata_i(mst_wdata_i),
    .mst_last_i(mst_last_i), .mst_ready_o(mst_ready_o), .mst_rdata_o(mst_rdata_o),
    .mst_err_o(mst_err_o), .mem_sel_o(mem_sel_o), .mem_addr_o(mem_addr_o),
    .mem_write_o(mem_write_o), .mem_size_o(mem_size_o), .mem_wdata_o(mem_wdata_o),
    .mem_last_o(mem_last_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .reg_req_o(reg_req_o), .reg_addr_o(reg_addr_o), .reg_write_o(reg_write_o),
    .reg_wdata_o(reg_wdata_o), .reg_fast_o(reg_fast_o), .reg_ack_i(reg_ack_i),
    .reg_rdata_i(reg_rdata_i));
  shb_target_model shb_target_model_inst (.clock_i(clock_i), .rst_i(rst_i),
    .delay_i(delay_i), .mem_sel_i(mem_sel_o), .mem_addr_i(mem_addr_o),
    .reg_req_i(reg_req_o), .reg_addr_i(reg_addr_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i), .reg_ack_o(reg_ack_i), .reg_rdata_o(reg_rdata_i));

  always #50 clock_i = ~clock_i;
  always @(negedge clock_i) begin
    if (mem_sel_o !== 3'h0) begin
      seen_sel = mem_sel_o;
      seen_maddr = mem_addr_o;
      seen_mctl = {mem_write_o, mem_size_o, mem_last_o};
      seen_mwd = mem_wdata_o;
    end
    if (reg_req_o === 1'b1) begin
      seen_fast = reg_fast_o;
      seen_raddr = reg_addr_o;
      seen_rw = reg_write_o;
      seen_rwd = reg_wdata_o;
    end
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("mismatch at %0t: run too long", $time);
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic beat(input int m, input logic [31:0] a, input logic w, input logic [1:0] s,
                      output logic [31:0] q, output logic e);
    int n;
    mst_req_i[m] <= 1'b1;
    mst_addr_i[m] <= a;
    mst_write_i[m] <= w;
    mst_size_i[m] <= s;
    mst_wdata_i[m] <= ~a;
    mst_last_i[m] <= 1'b1;
    n = 0;
    do begin @(negedge clock_i); n++; end while (mst_ready_o[m] !== 1'b1 && n < 300);
    q = mst_rdata_o;
    e = mst_err_o;
    @(posedge clock_i);
    mst_req_i[m] <= 1'b0;
    if (n >= 300) check(32'h0, 32'h1);
    @(posedge clock_i);
  endtask
  task automatic race(input logic [2:0] who, output int win);
    int n;
    for (int i = 0; i < 3; i++) begin
      mst_req_i[i] <= who[i];
      mst_addr_i[i] <= 32'h8000_0100;
      mst_write_i[i] <= 1'b0;
      mst_size_i[i] <= 2'h2;
      mst_last_i[i] <= 1'b1;
    end
    n = 0;
    win = -1;
    do begin @(negedge clock_i); n++; end while (mst_ready_o === 3'h0 && n < 300);
    for (int i = 0; i < 3; i++) if (mst_ready_o[i] === 1'b1) win = i;
    @(posedge clock_i);
    for (int i = 0; i < 3; i++) mst_req_i[i] <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic poll(output longint t);
    logic [31:0] q;
    logic        e;
    int          n;
    n = 0;
    do begin apb(1'b0, 12'h024, 32'h0, q, e); n++; end while (q[1] !== 1'b1 && n < 300);
    if (n >= 300) check(32'h0, 32'h1);
    t = cyc;
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    apb(1'b0, 12'h010, 32'h0, q, e);
    check(q, 32'h0000_0800);
    apb(1'b0, 12'h000, 32'h0, q, e);
    check(q, 32'h0);
    apb(1'b0, 12'h00c, 32'h0, q, e);
    check(q, 32'h0);
    wr(12'h014, 32'h0000_1234);
    apb(1'b0, 12'h014, 32'h0, q, e);
    check(q, 32'h0000_1234);
    wr(12'h014, 32'h0);
    apb(1'b0, 12'h030, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
  endtask
  task automatic t_prio();
    int w;
    race(3'b111, w);
    check(32'(w), 32'h0);
    race(3'b110, w);
    check(32'(w), 32'h1);
    wr(12'h004, 32'hf);
    race(3'b111, w);
    check(32'(w), 32'h1);
    wr(12'h008, 32'hf);
    race(3'b111, w);
    check(32'(w), 32'h1);
    wr(12'h004, 32'he);
    race(3'b111, w);
    check(32'(w), 32'h2);
    wr(12'h004, 32'h0);
    wr(12'h008, 32'h0);
  endtask
  task automatic t_regions();
    logic [31:0] at [7] = '{32'h8000_0040, 32'h8000_0044, 32'hc000_0000, 32'h4000_0010,
                            32'h4000_0010, 32'h7000_0010, 32'h8000_0001};
    logic        aw [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [1:0]  az [7] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0};
    logic [2:0]  xs [7] = '{3'h2, 3'h2, 3'h4, 3'h1, 3'h0, 3'h0, 3'h2};
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 7; i++) begin
      delay_i <= i[0] ? 4'h5 : 4'h0;
      seen_sel = 3'h0;
      beat(i % 3, at[i], aw[i], az[i], q, e);
      check({31'h0, e}, {31'h0, xs[i] == 3'h0});
      check({29'h0, seen_sel}, {29'h0, xs[i]});
      if (!aw[i] && xs[i] != 3'h0) check(q, at[i] ^ 32'h0000_a5a5);
      if (xs[i] != 3'h0) begin
        check(seen_maddr, at[i]);
        check({28'h0, seen_mctl}, {28'h0, aw[i], az[i], 1'b1});
        if (aw[i]) check(seen_mwd, ~at[i]);
      end
    end
    boot_mode <= 1'b1;
    seen_sel = 3'h0;
    beat(0, 32'h0000_0010, 1'b0, 2'h2, q, e);
    check({29'h0, seen_sel}, 32'h1);
    boot_mode <= 1'b0;
  endtask
  task automatic t_chip();
    logic [31:0] q;
    logic        e;
    delay_i <= 4'h6;
    beat(0, 32'h7000_0010, 1'b1, 2'h2, q, e);
    check({31'h0, e}, 32'h0);
    check(seen_raddr, 32'h7000_0010);
    check({31'h0, seen_rw}, 32'h1);
    check(seen_rwd, ~32'h7000_0010);
    beat(0, 32'h7000_0014, 1'b1, 2'h2, q, e);
    check({31'h0, e}, 32'h0);
    beat(0, 32'h7000_0010, 1'b0, 2'h2, q, e);
    check(q, 32'h7000_0010 ^ 32'h0000_5a5a);
    check({31'h0, seen_fast}, 32'h1);
    beat(1, 32'h7100_0000, 1'b0, 2'h2, q, e);
    check({31'h0, seen_fast}, 32'h0);
    beat(2, 32'h7101_0000, 1'b0, 2'h2, q, e);
    check({31'h0, seen_fast}, 32'h1);
  endtask
  task automatic t_tokens();
    logic [31:0] q;
    logic        e;
    int          w;
    longint      t1;
    longint      t2;
    wr(12'h010, 32'd200);
    wr(12'h018, 32'h3);
    wr(12'h004, 32'hf);
    wr(12'h00c, 32'h1);
    beat(1, 32'h8000_0000, 1'b0, 2'h2, q, e);
    poll(t1);
    beat(1, 32'h8000_0000, 1'b0, 2'h2, q, e);
    apb(1'b0, 12'h024, 32'h0, q, e);
    check(q, 32'h5);
    race(3'b011, w);
    check(32'(w), 32'h0);
    race(3'b001, w);
    check(32'(w), 32'h0);
    poll(t2);
    check({31'h0, t2 - t1 >= 196 && t2 - t1 <= 204}, 32'h1);
    race(3'b011, w);
    check(32'(w), 32'h1);
    wr(12'h00c, 32'h0);
    wr(12'h004, 32'h0);
  endtask
  task automatic end_of_test();
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 3; i++) begin
      mst_req_i[i] = 1'b0;
      mst_addr_i[i] = 32'h0;
      mst_write_i[i] = 1'b0;
      mst_size_i[i] = 2'h2;
      mst_wdata_i[i] = 32'h0;
      mst_last_i[i] = 1'b1;
    end
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    t_regs();
    t_prio();
    t_regions();
    t_chip();
    t_tokens();
    end_of_test();
  end
endmodule // tb_top
